/* File: dv/serial_config_bitstream_source_bench.sv */
// Purpose: self-checking bench for the serial bitstream source
// Assumes: power-on wait shortened to 16 clocks
// Notes: data sampled just before each serial clock rise
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module serial_config_bitstream_source_bench;
  import cfg_src_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, chip_select_n = 1'b1;
  logic legacy_mode = 1'b0, go = 1'b0, hold_low = 1'b0;
  logic prog_wr_en = 1'b0, prog_wr_bit = 1'b0;
  logic [ADDR_W-1:0] prog_wr_addr = ADDR_ZERO;
  logic serial_config_clock, oe_in, oe_out, oe_oe, serial_data_out;
  logic serial_data_oe, cascade_select_n, data_wire;
  logic next_data, next_data_oe, next_casc_n;
  int miscompares = 0;
  int n_compared = 0;
  always #10 clk_sys = !clk_sys;
  serial_config_bitstream_source #(.POR_CYCLES(16)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .serial_config_clock(serial_config_clock),
    .chip_select_n(chip_select_n), .oe_in(oe_in), .oe_out(oe_out),
    .oe_oe(oe_oe), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .cascade_select_n(cascade_select_n),
    .legacy_mode(legacy_mode), .prog_wr_en(prog_wr_en),
    .prog_wr_addr(prog_wr_addr), .prog_wr_bit(prog_wr_bit));
  // follower in the chain, built without cascading
  serial_config_bitstream_source #(
    .POR_CYCLES(16), .CASCADE_EN(1'b0)) u_next (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .serial_config_clock(serial_config_clock),
    .chip_select_n(cascade_select_n), .oe_in(oe_in), .oe_out(),
    .oe_oe(), .serial_data_out(next_data),
    .serial_data_oe(next_data_oe), .cascade_select_n(next_casc_n),
    .legacy_mode(legacy_mode), .prog_wr_en(prog_wr_en),
    .prog_wr_addr(prog_wr_addr), .prog_wr_bit(prog_wr_bit));
  target_model u_tgt (
    .clk_sys(clk_sys), .go(go), .hold_low(hold_low), .oe_out(oe_out),
    .oe_oe(oe_oe), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe),
    .serial_config_clock(serial_config_clock), .oe_in(oe_in),
    .data_wire(data_wire));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic img(input logic [ADDR_W-1:0] a);
    return ^(a & 11'h6B3);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse;
    go = 1'b1;
    @(posedge serial_config_clock);
    #1 go = 1'b0;
    @(negedge serial_config_clock);
    tick(8);
  endtask
  task automatic restart(input logic lg);
    hold_low = 1'b1;
    legacy_mode = lg;
    tick(5);
    hold_low = 1'b0;
    chip_select_n = 1'b0;
    tick(6);
  endtask
  task automatic stream(input logic [ADDR_W-1:0] last);
    for (int i = 0; i <= int'(last); i++) begin
      `CHK(data_wire, img(i[ADDR_W-1:0]))
      `CHK(cascade_select_n, 1'b1)
      pulse();
    end
    `CHK(serial_data_oe, 1'b0)
    `CHK(cascade_select_n, 1'b0)
  endtask
  task automatic stop_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic power_on_wait;
    tick(4);
    `CHK(oe_in, 1'b0)
    `CHK(oe_oe, 1'b1)
    `CHK(oe_out, 1'b0)
    for (int i = 0; i < 2048; i++) begin
      prog_wr_en = 1'b1;
      prog_wr_addr = i[ADDR_W-1:0];
      prog_wr_bit = img(i[ADDR_W-1:0]);
      tick(1);
    end
    prog_wr_en = 1'b0;
    `CHK(oe_in, 1'b1)
    `CHK(serial_data_oe, 1'b0)
    `CHK(cascade_select_n, 1'b1)
  endtask
  task automatic full_image;
    restart(1'b0);
    stream(FULL_LAST);
    // follower takes over with its first bit
    `CHK(next_data_oe, 1'b1)
    `CHK(next_data, img(ADDR_ZERO))
    `CHK(next_casc_n, 1'b1)
    pulse();
    `CHK(serial_data_oe, 1'b0)
    `CHK(next_data, img(ADDR_ONE))
  endtask
  task automatic reload_no_wait;
    restart(1'b0);
    `CHK(oe_oe, 1'b0)
    `CHK(serial_data_oe, 1'b1)
    `CHK(data_wire, img(ADDR_ZERO))
  endtask
  task automatic pause_on_deselect;
    restart(1'b0);
    repeat (3) pulse();
    chip_select_n = 1'b1;
    tick(4);
    `CHK(serial_data_oe, 1'b0)
    pulse();
    chip_select_n = 1'b0;
    tick(6);
    `CHK(data_wire, img(11'h003))
  endtask
  task automatic legacy_image;
    restart(1'b1);
    stream(LEGACY_LAST);
  endtask
  initial begin
    tick(16);
    rst_n = 1'b1;
    power_on_wait();
    full_image();
    reload_no_wait();
    pause_on_deselect();
    legacy_image();
    stop_test();
  end
  initial begin
    // about 76k clocks expected; give up at 90k
    #1800us;
    miscompares++;
    stop_test();
  end
endmodule

/* File: dv/target_model.sv */
// Purpose: target side making serial clock and resolving pin levels
// Assumes: 8 clk_sys per serial clock phase
// Notes: released data pin shows the inverse of its last driven bit
`timescale 1ns/1ps
module target_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic hold_low,
  input wire logic oe_out,
  input wire logic oe_oe,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  output logic serial_config_clock,
  output logic oe_in,
  output logic data_wire
);
  logic [2:0] ph_q = 3'h0;
  logic last_q = 1'b0;
  logic sclk_q = 1'b0;
  assign serial_config_clock = sclk_q;
  // enable wire has a pull-up
  assign oe_in = !(hold_low || (oe_oe && !oe_out));
  assign data_wire = serial_data_oe ? serial_data_out : !last_q;
  always @(posedge clk_sys) begin
    if (serial_data_oe) last_q <= serial_data_out;
    if (go || sclk_q) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) sclk_q <= !sclk_q;
    end else ph_q <= 3'h0;
  end
endmodule

/* File: verilog/cfg_src_pkg.sv */
// Purpose: shared constants and types for the serial bitstream source
// Assumes: 50 MHz system clock, one bit of image per address
// Notes: image depths are fixed; legacy depth is the smaller variant
package cfg_src_pkg;
  localparam int ADDR_W = 11;
  localparam logic [ADDR_W-1:0] FULL_LAST = 11'h7FF;
  localparam logic [ADDR_W-1:0] LEGACY_LAST = 11'h3FF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
  localparam int CLK_PERIOD_NS = 20;
  localparam int POR_TIME_MS = 200;
  // longest time: rounds down
  localparam int POR_CYCLES_DOC = POR_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 24;
  localparam logic [POR_CNT_W-1:0] POR_CNT_ONE = 24'h000001;
  localparam logic [POR_CNT_W-1:0] POR_CNT_ZERO = 24'h000000;

  typedef enum logic [1:0] {
    ST_POR  = 2'h0,
    ST_IDLE = 2'h1,
    ST_SEND = 2'h3,
    ST_DONE = 2'h2
  } src_state_t;
endpackage

/* File: verilog/image_bit_store.sv */
// Purpose: bit-wide image memory with a registered read port
// Assumes: written by the programming side, read once per cycle
// Notes: read data lag the read address by one clock
`timescale 1ns/1ps
module image_bit_store
  import cfg_src_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic wr_bit,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic rd_bit
);
  logic mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_bit;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_bit <= 1'b0;
    end else begin
      rd_bit <= mem[rd_addr];
    end
  end
endmodule

/* File: verilog/serial_config_bitstream_source.sv */
// Purpose: serial configuration memory streaming an image to a target
// Assumes: target drives the serial clock and the output-enable line
// Notes: pins are sampled on clk_sys through two flip-flops
//
// What this block does
// - power-on delay once, never on reconfiguration
// - stored image leaves one bit at a time
// - legacy image makes device act like smaller variant
// - cascade output feeds next memory's chip select
// - cascading is a build option
// - rising clock edge advances counter when allowed
// - enable low resets counter, high permits output
// - cascade select low once the bit at counter maximum is taken
// - data floats when deselected or finished
`timescale 1ns/1ps
module serial_config_bitstream_source
  import cfg_src_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYCLES_DOC,
  parameter bit CASCADE_EN = 1'b1
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic serial_config_clock,
  input wire logic chip_select_n,
  input wire logic oe_in,
  output logic oe_out,
  output logic oe_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic cascade_select_n,
  input wire logic legacy_mode,
  input wire logic prog_wr_en,
  input wire logic [ADDR_W-1:0] prog_wr_addr,
  input wire logic prog_wr_bit
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic oe_s1;
    logic oe_s2;
    logic cs_s1;
    logic cs_s2;
    src_state_t state;
    logic [POR_CNT_W-1:0] por_cnt;
    logic [ADDR_W-1:0] addr;
    logic data;
    logic data_oe;
    logic casc_n;
    logic oe_drv;
    logic oe_en;
  } src_regs_t;

  localparam src_regs_t REGS_RST = '{
    sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_s3: 1'b0,
    oe_s1: 1'b0, oe_s2: 1'b0, cs_s1: 1'b1, cs_s2: 1'b1,
    state: ST_POR, por_cnt: POR_CNT_ZERO, addr: ADDR_ZERO,
    data: 1'b0, data_oe: 1'b0, casc_n: 1'b1,
    oe_drv: 1'b0, oe_en: 1'b1
  };
  localparam logic [POR_CNT_W-1:0] POR_LAST =
    POR_CNT_W'(POR_CYCLES) - POR_CNT_ONE;

  src_regs_t q, d;
  logic rd_bit;
  logic sclk_rise;
  logic send_ok;
  logic [ADDR_W-1:0] img_last;

  image_bit_store u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(prog_wr_en),
    .wr_addr(prog_wr_addr),
    .wr_bit(prog_wr_bit),
    .rd_addr(q.addr),
    .rd_bit(rd_bit)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign sclk_rise = q.sclk_s2 & ~q.sclk_s3;
  assign send_ok = q.oe_s2 & ~q.cs_s2;
  // legacy image ends at the smaller variant's depth
  assign img_last = legacy_mode ? LEGACY_LAST : FULL_LAST;

  always_comb begin
    d = q;
    d.sclk_s1 = serial_config_clock;
    d.sclk_s2 = q.sclk_s1;
    d.sclk_s3 = q.sclk_s2;
    d.oe_s1 = oe_in;
    d.oe_s2 = q.oe_s1;
    d.cs_s1 = chip_select_n;
    d.cs_s2 = q.cs_s1;
    d.oe_drv = 1'b0;
    d.data = rd_bit;
    case (q.state)
      ST_POR: begin
        // hold enable low until supplies settle, first power-up only
        d.oe_en = 1'b1;
        if (q.por_cnt == POR_LAST) begin
          d.state = ST_IDLE;
          d.oe_en = 1'b0;
        end else begin
          d.por_cnt = q.por_cnt + POR_CNT_ONE;
        end
      end
      ST_IDLE: begin
        if (send_ok) begin
          d.state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (q.cs_s2) begin
          d.state = ST_IDLE;
        end else if (sclk_rise && send_ok) begin
          if (q.addr == img_last) begin
            d.state = ST_DONE;
          end else begin
            d.addr = q.addr + ADDR_ONE;
          end
        end
      end
      ST_DONE: begin
        d.state = ST_DONE;
      end
      default: begin
        d.state = ST_POR;
      end
    endcase
    // enable low clears the counter; never re-enters power-on wait
    if (q.state != ST_POR && !q.oe_s2) begin
      d.addr = ADDR_ZERO;
      d.state = ST_IDLE;
    end
    // low only once the last bit is taken: the next edge is the follower's
    d.casc_n = ~(CASCADE_EN && d.addr == img_last &&
      d.state == ST_DONE);
    d.data_oe = (d.state == ST_SEND) && q.oe_s2 && !q.cs_s2;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  assign oe_out = q.oe_drv;
  assign oe_oe = q.oe_en;
  assign serial_data_out = q.data;
  assign serial_data_oe = q.data_oe;
  assign cascade_select_n = q.casc_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_adv;
    sclk_rise && q.state == ST_SEND && send_ok;
  endsequence

  property p_por_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      q.state == ST_POR |-> oe_oe && !oe_out;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("enable not held low during power-on wait");

  property p_por_once;
    @(posedge clk_sys) disable iff (!rst_n)
      q.state != ST_POR |=> q.state != ST_POR && !oe_oe;
  endproperty
  a_por_once: assert property (p_por_once)
    else $error("power-on wait repeated");

  property p_addr_adv;
    @(posedge clk_sys) disable iff (!rst_n)
      s_adv ##0 (q.addr != img_last) |=>
        q.addr == $past(q.addr) + ADDR_ONE;
  endproperty
  a_addr_adv: assert property (p_addr_adv)
    else $error("counter did not advance on clock edge");

  property p_addr_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !sclk_rise && q.state == ST_SEND && q.oe_s2 |=> $stable(q.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("counter moved without a clock edge");

  property p_oe_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      q.state != ST_POR && !q.oe_s2 |=>
        q.addr == ADDR_ZERO && cascade_select_n;
  endproperty
  a_oe_reset: assert property (p_oe_reset)
    else $error("enable low did not clear counter");

  property p_legacy_end;
    @(posedge clk_sys) disable iff (!rst_n)
      s_adv ##0 (legacy_mode && q.addr == LEGACY_LAST) |=> q.state == ST_DONE;
  endproperty
  a_legacy_end: assert property (p_legacy_end)
    else $error("legacy image did not end at its depth");

  property p_casc;
    @(posedge clk_sys) disable iff (!rst_n)
      q.state == ST_DONE && q.oe_s2 |-> cascade_select_n == !CASCADE_EN;
  endproperty
  a_casc: assert property (p_casc)
    else $error("cascade select wrong after image end");

  property p_casc_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      q.state == ST_SEND |-> cascade_select_n;
  endproperty
  a_casc_wait: assert property (p_casc_wait)
    else $error("cascade select low before image end");

  property p_float;
    @(posedge clk_sys) disable iff (!rst_n)
      q.cs_s2 || q.state == ST_DONE |=> !serial_data_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("data driven while deselected or finished");

  property p_bit;
    @(posedge clk_sys) disable iff (!rst_n)
      q.state == ST_SEND ##1 q.state == ST_SEND |->
        serial_data_out == $past(rd_bit);
  endproperty
  a_bit: assert property (p_bit)
    else $error("data bit not taken from image");
endmodule
